// ### rtl/aims_mux_select.sv
// Functional notes
// [R1] bit 31: B negative, input 1 or low_reference
// [R2] bits 27-24: B positive input number
// [R3] bit 23: A negative, input 1 or low_reference
// [R4] bits 19-16: A positive input number
// [R5] scan mask bit k includes input k
// [R6] unimplemented bits read zero, writes ignored
// [R7] all fields zero after reset; status scan index reads 4'hf from the first clock edge
// [R8] alternate: A first, then B/A alternating
// [R9] scan enable takes positive input from mask
// [R10] scan ascends enabled inputs, wraps around
`include "aims_params.svh"
module aims_mux_select #(
  parameter int SEL_W  = 4,
  parameter int MASK_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              sample_done,
  output aims_pkg::aims_mux_t    mux_sel,
  output logic                   setting_b_active
);
  logic [31:0]       insel_reg;
  logic [MASK_W-1:0] scan_mask_reg;
  logic              alternate_sampling_reg;
  logic              scan_enable_reg;
  logic              use_b_reg;
  logic              use_b_next;
  logic [SEL_W-1:0]  scan_idx_reg;
  logic [SEL_W-1:0]  scan_idx_next;
  logic              ack_reg;
  logic [31:0]       wmask;
  logic              wr_go;
  logic              rd_take;
  logic              hit_insel;
  logic              hit_scan;
  logic              hit_ctrl;
  logic              hit_stat;
  logic [31:0]       rd_word;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // one decoder for every register, so reads and writes agree
  function automatic logic sel_hit(input logic [3:0] a,
                                   input logic [3:0] ofs);
    sel_hit = (a == ofs);
  endfunction

  // next enabled input above cur, wrapping; holds cur if mask empty
  function automatic logic [3:0] next_scan(input logic [15:0] m,
                                           input logic [3:0]  cur);
    logic [4:0] k;
    logic [3:0] idx;
    logic       found;
    next_scan = cur;
    found = 1'b0;
    for (k = 5'h01; k <= 5'h10; k = k + 5'h01) begin
      idx = cur + k[3:0];
      if (!found && m[idx]) begin
        next_scan = idx;
        found = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------
  // avalon slave: one wait cycle per access
  // ----------------------------------------
  assign wmask     = be_mask(avs_byteenable);
  assign wr_go     = avs_write && ack_reg;
  // read data latched when the request is first seen, so it
  // already stands in the cycle in which waitrequest is low
  assign rd_take   = avs_read && !ack_reg;
  assign hit_insel = sel_hit(avs_address, `AIMS_OFS_INSEL);
  assign hit_scan  = sel_hit(avs_address, `AIMS_OFS_SCAN);
  assign hit_ctrl  = sel_hit(avs_address, `AIMS_OFS_CTRL);
  assign hit_stat  = sel_hit(avs_address, `AIMS_OFS_STAT);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      insel_reg <= `AIMS_INSEL_RST; // [R7]
    end else if (wr_go && hit_insel) begin
      // masked write keeps unimplemented bits at zero
      insel_reg <= ((avs_writedata & wmask) | (insel_reg & ~wmask))
                   & `AIMS_INSEL_MASK; // [R1] [R2] [R3] [R4] [R6]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scan_mask_reg <= `AIMS_SCAN_RST; // [R7]
    end else if (wr_go && hit_scan) begin
      scan_mask_reg <= (avs_writedata[15:0] & wmask[15:0])
                       | (scan_mask_reg & ~wmask[15:0]); // [R5] [R6]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alternate_sampling_reg <= 1'b0;
      scan_enable_reg        <= 1'b0;
    end else if (wr_go && hit_ctrl && avs_byteenable[0]) begin
      alternate_sampling_reg <= avs_writedata[`AIMS_ALT_BIT];
      scan_enable_reg        <= avs_writedata[`AIMS_SCAN_BIT];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped offsets fall through to zero
  always_comb begin
    rd_word = 32'h00000000;
    if (hit_insel) begin
      rd_word = insel_reg; // [R6]
    end else if (hit_scan) begin
      rd_word = {16'h0000, scan_mask_reg}; // [R6]
    end else if (hit_ctrl) begin
      rd_word = {30'h00000000, scan_enable_reg, alternate_sampling_reg};
    end else if (hit_stat) begin
      rd_word = {27'h0000000, use_b_reg, scan_idx_reg};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_take) begin
      avs_readdata <= rd_word;
    end
  end

  // ----------------------------------------
  // sample sequencing
  // ----------------------------------------
  // turning alternate off or on restarts with setting a
  always_comb begin
    use_b_next = use_b_reg;
    if (!alternate_sampling_reg) begin
      use_b_next = 1'b0; // [R8]
    end else if (sample_done) begin
      use_b_next = !use_b_reg; // [R8]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      use_b_reg <= 1'b0;
    end else begin
      use_b_reg <= use_b_next;
    end
  end

  // with scan on, an empty mask holds the index; nothing to step to
  always_comb begin
    scan_idx_next = scan_idx_reg;
    if (!scan_enable_reg) begin
      // parked on the lowest enabled input for the first sample
      scan_idx_next = next_scan(scan_mask_reg, 4'hf); // [R10]
    end else if (sample_done || !scan_mask_reg[scan_idx_reg]) begin
      // a cleared mask bit moves on at once, not a sample late
      scan_idx_next = next_scan(scan_mask_reg, scan_idx_reg); // [R10]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scan_idx_reg <= 4'h0;
    end else begin
      scan_idx_reg <= scan_idx_next;
    end
  end

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  // flag and mux both follow use_b_reg, so they never disagree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      setting_b_active <= 1'b0;
    end else begin
      setting_b_active <= use_b_reg; // [R8]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mux_sel <= '0;
    end else begin
      if (use_b_reg) begin
        mux_sel.neg_sel <= insel_reg[`AIMS_NEG_B_BIT]; // [R1]
        mux_sel.pos_sel <= insel_reg[`AIMS_POS_B_HI:`AIMS_POS_B_LO]; // [R2]
      end else begin
        mux_sel.neg_sel <= insel_reg[`AIMS_NEG_A_BIT]; // [R3]
        mux_sel.pos_sel <= insel_reg[`AIMS_POS_A_HI:`AIMS_POS_A_LO]; // [R4]
      end
      if (scan_enable_reg) begin
        mux_sel.pos_sel <= scan_idx_reg; // [R9] [R5]
      end
    end
  end
endmodule // aims_mux_select

// ### rtl/aims_params.svh
`ifndef AIMS_PARAMS_SVH
`define AIMS_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define AIMS_OFS_INSEL   4'h0
`define AIMS_OFS_SCAN    4'h4
`define AIMS_OFS_CTRL    4'h8
`define AIMS_OFS_STAT    4'hc
// ----------------------------------------
// field positions
// ----------------------------------------
`define AIMS_NEG_B_BIT   31
`define AIMS_POS_B_HI    27
`define AIMS_POS_B_LO    24
`define AIMS_NEG_A_BIT   23
`define AIMS_POS_A_HI    19
`define AIMS_POS_A_LO    16
`define AIMS_ALT_BIT     0
`define AIMS_SCAN_BIT    1
// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define AIMS_INSEL_RST   32'h00000000
`define AIMS_SCAN_RST    16'h0000
`define AIMS_INSEL_MASK  32'h8f8f0000
`endif

// ### rtl/aims_pkg.sv
package aims_pkg;
  typedef struct packed {
    logic       neg_sel;
    logic [3:0] pos_sel;
  } aims_mux_t;
endpackage

// ### verification/aims_mux_select_asserts.sv
// ------
// port checks
// ------
module aims_mux_select_asserts (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic [3:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [3:0]          avs_byteenable,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic                sample_done,
  input wire aims_pkg::aims_mux_t mux_sel,
  input wire logic                setting_b_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire ack = !avs_waitrequest;
  wire rd0 = ack && avs_read && avs_address == 4'h0;
  wire wr0 = ack && avs_write && avs_address == 4'h0;
  wire idle = !sample_done && !avs_write;
  property p_one; ack |=> !ack; endproperty
  a_one: assert property (p_one) else $error("wait low twice");
  property p_ans; (avs_read || avs_write) && !ack |-> ##[1:2] ack;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_rd0; rd0 |-> (avs_readdata & 32'h7070ffff) == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("select spare bits");
  property p_rd4; ack && avs_read && avs_address == 4'h4 |->
    avs_readdata[31:16] == 16'h0; endproperty
  a_rd4: assert property (p_rd4) else $error("mask spare bits");
  property p_hold; !(avs_read && !ack) |=> $stable(avs_readdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // settle window avoids races with a mid-write sample step
  property p_neg; wr0 && avs_byteenable == 4'hf && !sample_done
    ##1 !sample_done [*3] |->
    mux_sel.neg_sel == (setting_b_active ? $past(avs_writedata[31], 3)
    : $past(avs_writedata[23], 3)); endproperty
  a_neg: assert property (p_neg) else $error("negative input");
  property p_bhold; idle [*3] |=> $stable(setting_b_active); endproperty
  a_bhold: assert property (p_bhold) else $error("b moved idle");
  property p_bback; setting_b_active && sample_done |->
    ##[1:2] !setting_b_active; endproperty
  a_bback: assert property (p_bback) else $error("b not back");
  c_alt: cover property (setting_b_active && sample_done);
  c_rd: cover property (rd0);
  c_wr: cover property (wr0);
endmodule // aims_mux_select_asserts
bind aims_mux_select aims_mux_select_asserts aims_mux_select_asserts_inst (.*);

// ### verification/adc_input_mux_select_bench.sv
// ------
// bench
// ------
module adc_input_mux_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic sample_done = 1'b0, avs_waitrequest, setting_b_active;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf, c;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, d;
  aims_pkg::aims_mux_t mux_sel;
  integer n_fail = 0, cmp_count = 0, seed = 44446, i;
  aims_mux_select aims_mux_select_inst (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input [31:0] v);
    int k;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= v;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      n_fail++;
      conclude;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  // mux outputs lag a cycle, so look three edges on
  task automatic pulse;
    sample_done <= 1'b1;
    @(posedge clk_sys);
    sample_done <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  function automatic logic [3:0] nxt(input [15:0] m, input [3:0] p);
    for (int j = 1; j <= 16; j++)
      if (m[4'(p + j)]) return 4'(p + j);
    return p;
  endfunction
  initial begin
    repeat (2) @(posedge clk_sys);
    chk("rst_mux", mux_sel, 32'h0);
    chk("rst_b", setting_b_active, 32'h0);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (i = 0; i < 3; i++) begin
      bus(1'b0, i == 2 ? 4'h6 : 4'(4 * i), 32'h0);
      chk("rst_reg", q, 32'h0);
    end
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      d = i == 0 ? 32'hffffffff : $random(seed);
      bus(1'b1, 4'h0, d);
      bus(1'b0, 4'h0, 32'h0);
      chk("insel", q, d & 32'h8f8f0000);
      chk("mux_a", mux_sel, {d[23], d[19:16]});
      bus(1'b1, 4'h4, d);
      bus(1'b0, 4'h4, 32'h0);
      chk("scan", q, d & 32'h0000ffff);
    end
    bus(1'b1, 4'h0, 32'h0);
    avs_byteenable <= 4'h8;
    bus(1'b1, 4'h0, 32'hffffffff);
    avs_byteenable <= 4'hf;
    bus(1'b0, 4'h0, 32'h0);
    chk("lane", q, 32'h8f000000);
    $display("field test done");
    bus(1'b1, 4'h0, 32'h85020000);
    bus(1'b1, 4'h8, 32'h1);
    repeat (2) @(posedge clk_sys);
    for (i = 0; i < 3; i++) begin
      chk("alt", mux_sel, i[0] ? 32'h15 : 32'h02);
      chk("b_act", setting_b_active, 32'(i[0]));
      pulse;
    end
    bus(1'b0, 4'h8, 32'h0);
    chk("ctrl", q, 32'h1);
    bus(1'b0, 4'hc, 32'h0);
    chk("stat", q, {27'h0, 1'b1, nxt(d[15:0], 4'hf)});
    bus(1'b1, 4'h4, 32'h8005);
    bus(1'b1, 4'h8, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk("alt_off", setting_b_active, 32'h0);
    c = 4'h0;
    for (i = 0; i < 5; i++) begin
      chk("scan_pos", mux_sel, {1'b0, c});
      pulse;
      c = nxt(16'h8005, c);
    end
    $display("sample test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("rst2_mux", mux_sel, 32'h0);
    chk("rst2_b", setting_b_active, 32'h0);
    for (i = 0; i < 2; i++) begin
      bus(1'b0, 4'(4 * i), 32'h0);
      chk("rst2_reg", q, 32'h0);
    end
    bus(1'b0, 4'hc, 32'h0);
    chk("rst2_stat", q, {27'h0, 1'b0, nxt(16'h0, 4'hf)});
    $display("second reset test done");
    conclude;
  end
endmodule // adc_input_mux_select_bench
